// ### logic/hcbi_host_if.sv
// Host processor bus interface: cycle completion, pipelining and snoops.
// Assumes a back end that paces beats and a PCI side that asks for snoops.
`timescale 1ns/1ps
`default_nettype none
`include "hcbi_map.svh"

module hcbi_host_if (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Processor address and cycle definition
   input wire logic [`HCBI_ADDR_W-1:0] host_addr_lines_i,
   output logic [`HCBI_ADDR_W-1:0] host_addr_lines_o,
   output logic host_addr_lines_oe_o,
   input wire logic [`HCBI_BE_W-1:0] host_byte_lane_enables_n_i,
   input wire logic cycle_addr_strobe_n_i,
   input wire logic write_or_read_sel_i,
   input wire logic mem_or_io_sel_i,
   input wire logic data_or_code_sel_i,
   input wire logic host_locked_cycle_n_i,
   input wire logic cpu_cacheable_n_i,
   input wire logic sys_mgmt_active_n_i,
   input wire logic snoop_hit_modified_n_i,
   // Processor data
   input wire logic [`HCBI_DATA_W-1:0] host_data_lines_i,
   output logic [`HCBI_DATA_W-1:0] host_data_lines_o,
   output logic host_data_lines_oe_o,
   // Processor control outputs
   output logic burst_ready_n_o,
   output logic next_addr_n_o,
   output logic addr_hold_req_n_o,
   output logic snoop_addr_strobe_n_o,
   output logic cpu_backoff_n_o,
   output logic cache_en_invalidate_o,
   // Back end cycle side
   output logic req_vld_o,
   output hcbi_pkg::hcbi_cycle_t req_o,
   input wire logic beat_rdy_i,
   input wire logic ken_i,
   input wire logic pipe_en_i,
   input wire logic [`HCBI_DATA_W-1:0] rd_data_i,
   output logic [`HCBI_DATA_W-1:0] wr_data_o,
   output logic wr_vld_o,
   output logic cyc_done_o,
   output logic cyc_abort_o,
   input wire logic backoff_req_i,
   // PCI snoop side
   input wire logic snoop_req_i,
   input wire hcbi_pkg::hcbi_snoop_t snoop_i,
   output logic snoop_ack_o,
   output logic snoop_hit_o,
   output logic line_block_o,
   // Status
   output logic locked_seq_o,
   output logic smm_active_o
);
   import hcbi_pkg::*;

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   hcbi_state_t state_r;                 // Interface state
   hcbi_state_t state_nxt;
   hcbi_cycle_t pend_r;                  // Pipelined cycle waiting to run
   logic pend_vld_r;
   hcbi_snoop_t snp_r;                   // Snoop being run
   logic [`HCBI_BEAT_W-1:0] beats_r;     // Ready strobes given so far
   logic [`HCBI_BEAT_W-1:0] total_r;     // Strobes this cycle needs
   logic [`HCBI_HITM_CNT_W-1:0] hcnt_r;  // Wait before sampling hit
   logic na_done_r;                      // Next-address already offered
   logic dec_vld;                        // Fresh cycle from the decoder
   hcbi_cycle_t dec_cyc;

   // Decoder of the address strobe and definition pins
   hcbi_cycle_decode u_decode (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .cycle_addr_strobe_n_i(cycle_addr_strobe_n_i),
      .host_addr_lines_i(host_addr_lines_i),
      .host_byte_lane_enables_n_i(host_byte_lane_enables_n_i),
      .write_or_read_sel_i(write_or_read_sel_i),
      .mem_or_io_sel_i(mem_or_io_sel_i),
      .data_or_code_sel_i(data_or_code_sel_i),
      .host_locked_cycle_n_i(host_locked_cycle_n_i),
      .cpu_cacheable_n_i(cpu_cacheable_n_i),
      .sys_mgmt_active_n_i(sys_mgmt_active_n_i),
      .dec_vld_o(dec_vld),
      .dec_cyc_o(dec_cyc)
   );

   // -------------------------------------------------------------------
   // Decode of the current step
   // -------------------------------------------------------------------
   wire logic idle_w = (state_r == HCBI_IDLE);
   wire logic in_cyc_w = (state_r == HCBI_CYCLE);
   wire logic boff_w = ~cpu_backoff_n_o;              // Back-off in force
   // A cycle starts only from a seen strobe
   wire logic start_w = idle_w & (pend_vld_r | dec_vld);
   wire hcbi_cycle_t start_cyc_w = pend_vld_r ? pend_r : dec_cyc;
   // A locked sequence defers snoops
   wire logic snoop_go_w = idle_w & ~start_w & snoop_req_i & ~locked_seq_o;
   wire logic abort_w = in_cyc_w & boff_w;
   wire logic beat_w = in_cyc_w & beat_rdy_i & ~boff_w;
   wire logic first_w = (beats_r == `HCBI_BEAT_ZERO);
   // Fills and write-backs burst four, all else one
   wire logic burst_w = req_o.mem & req_o.cacheable & (req_o.write | ken_i);
   wire logic [`HCBI_BEAT_W-1:0] need_w = first_w ?
      (burst_w ? `HCBI_BEATS_BURST : `HCBI_BEATS_SINGLE) : total_r;
   wire logic [`HCBI_BEAT_W-1:0] beats_inc_w = beats_r + `HCBI_BEAT_ONE;
   wire logic last_w = beat_w & (beats_inc_w == need_w);
   wire logic hit_w = (state_r == HCBI_SNWAIT) & (hcnt_r == `HCBI_HITM_LAST);
   wire logic hitm_w = hit_w & hcbi_act(snoop_hit_modified_n_i);
   // Write-back of the modified line ends the block
   wire logic wb_done_w = last_w & req_o.write & req_o.cacheable;
   // A cycle that arrives while busy waits in the pipeline slot
   wire logic park_w = dec_vld & ~(idle_w & ~pend_vld_r);
   wire logic na_w = in_cyc_w & pipe_en_i & ~na_done_r & ~pend_vld_r & ~boff_w;

   // Next state
   assign state_nxt =
      start_w ? HCBI_CYCLE :
      snoop_go_w ? HCBI_AHOLD :
      (abort_w | last_w) ? HCBI_IDLE :
      (state_r == HCBI_AHOLD) ? HCBI_STROBE :
      (state_r == HCBI_STROBE) ? HCBI_SNWAIT :
      hit_w ? HCBI_IDLE : state_r;

   // -------------------------------------------------------------------
   // Sequencer registers, all on the host bus clock
   // -------------------------------------------------------------------
   // State, reset to idle
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         state_r <= HCBI_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end
   // Current cycle and start pulse
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         req_o <= '0;
         req_vld_o <= 1'b0;
      end else begin
         req_o <= start_w ? start_cyc_w : req_o;
         req_vld_o <= start_w;
      end
   end
   // Pipeline slot; a back-off during a cycle drops the parked cycle
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         pend_vld_r <= 1'b0;
         pend_r <= '0;
      end else begin
         pend_vld_r <= park_w | (pend_vld_r & ~start_w & ~abort_w);
         pend_r <= park_w ? dec_cyc : pend_r;
      end
   end
   // Beat counting
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         beats_r <= `HCBI_BEAT_ZERO;
         total_r <= `HCBI_BEATS_SINGLE;
      end else begin
         beats_r <= start_w ? `HCBI_BEAT_ZERO : (beat_w ? beats_inc_w : beats_r);
         total_r <= (beat_w & first_w) ? need_w : total_r;
      end
   end

   // -------------------------------------------------------------------
   // Cycle completion outputs
   // -------------------------------------------------------------------
   // One ready strobe per beat, read data on the full width
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         burst_ready_n_o <= 1'b1;
         host_data_lines_o <= `HCBI_DATA_ZERO;
         host_data_lines_oe_o <= 1'b0;
      end else begin
         burst_ready_n_o <= ~beat_w;
         host_data_lines_o <= rd_data_i;
         host_data_lines_oe_o <= beat_w & ~req_o.write;
      end
   end
   // Write data to the back end, lanes travel in req_o.be
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         wr_data_o <= `HCBI_DATA_ZERO;
         wr_vld_o <= 1'b0;
      end else begin
         wr_data_o <= host_data_lines_i;
         wr_vld_o <= beat_w & req_o.write;
      end
   end
   // End and abort pulses
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         cyc_done_o <= 1'b0;
         cyc_abort_o <= 1'b0;
      end else begin
         cyc_done_o <= last_w;
         cyc_abort_o <= abort_w;
      end
   end
   // Next-address offered once per cycle
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         next_addr_n_o <= 1'b1;
         na_done_r <= 1'b0;
      end else begin
         next_addr_n_o <= ~na_w;
         na_done_r <= ~start_w & (na_done_r | na_w);
      end
   end
   // Back-off follows the request on the next edge
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         cpu_backoff_n_o <= 1'b1;
      end else begin
         cpu_backoff_n_o <= ~backoff_req_i;
      end
   end
   // Cache enable with the first beat, invalidate with the snoop strobe
   wire logic ken_nxt = (state_r == HCBI_AHOLD) ? snp_r.write :
      (beat_w & first_w) ? ~ken_i :
      (idle_w | hit_w) ? 1'b1 : cache_en_invalidate_o;
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         cache_en_invalidate_o <= 1'b1;
      end else begin
         cache_en_invalidate_o <= ken_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Inquiry sequence
   // -------------------------------------------------------------------
   // Snoop capture and hit wait counter
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         snp_r <= '0;
         hcnt_r <= `HCBI_HITM_CNT_ZERO;
      end else begin
         snp_r <= snoop_go_w ? snoop_i : snp_r;
         hcnt_r <= (state_r == HCBI_SNWAIT) ? hcnt_r + `HCBI_HITM_CNT_ONE
                                            : `HCBI_HITM_CNT_ZERO;
      end
   end
   // Address hold for the whole inquiry
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         addr_hold_req_n_o <= 1'b1;
      end else begin
         addr_hold_req_n_o <= snoop_go_w ? 1'b0 : (hit_w ? 1'b1 : addr_hold_req_n_o);
      end
   end
   // Snoop address and strobe for one cycle
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         snoop_addr_strobe_n_o <= 1'b1;
         host_addr_lines_o <= `HCBI_ADDR_ZERO;
         host_addr_lines_oe_o <= 1'b0;
      end else begin
         snoop_addr_strobe_n_o <= ~(state_r == HCBI_AHOLD);
         host_addr_lines_o <= snp_r.addr;
         host_addr_lines_oe_o <= (state_r == HCBI_AHOLD);
      end
   end
   // Snoop answer and line block; a new hit wins over the clear
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         snoop_ack_o <= 1'b0;
         snoop_hit_o <= 1'b0;
         line_block_o <= 1'b0;
      end else begin
         snoop_ack_o <= hit_w;
         snoop_hit_o <= hit_w ? hitm_w : snoop_hit_o;
         line_block_o <= hitm_w | (line_block_o & ~wb_done_w);
      end
   end
   // Lock and management-mode status
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         locked_seq_o <= 1'b0;
         smm_active_o <= 1'b0;
      end else begin
         locked_seq_o <= hcbi_act(host_locked_cycle_n_i);
         smm_active_o <= hcbi_act(sys_mgmt_active_n_i);
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   logic [`HCBI_BEAT_W-1:0] chk_cnt_r; // Ready strobes seen this cycle
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         chk_cnt_r <= `HCBI_BEAT_ZERO;
      end else begin
         chk_cnt_r <= req_vld_o ? `HCBI_BEAT_ZERO : chk_cnt_r + {2'h0, ~burst_ready_n_o};
      end
   end

   sequence s_hold_strobe;
      !addr_hold_req_n_o && snoop_addr_strobe_n_o
      ##1 !addr_hold_req_n_o && !snoop_addr_strobe_n_o;
   endsequence
   sequence s_hold_wait;
      (!addr_hold_req_n_o && snoop_addr_strobe_n_o) [*2]
      ##1 (addr_hold_req_n_o && snoop_ack_o);
   endsequence
   a_addr_drive_snoop: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      host_addr_lines_oe_o |-> !snoop_addr_strobe_n_o && !addr_hold_req_n_o)
      else $error("address lines driven outside an inquiry");
   a_data_read_only: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      host_data_lines_oe_o |-> !burst_ready_n_o && !req_o.write)
      else $error("data driven without a read ready strobe");
   a_start_on_strobe: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      req_vld_o |-> $past(dec_vld) || $past(pend_vld_r))
      else $error("cycle started without an address strobe");
   a_beat_count_end: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      cyc_done_o |-> !burst_ready_n_o &&
      (chk_cnt_r == `HCBI_BEAT_ZERO || chk_cnt_r + `HCBI_BEAT_ONE == `HCBI_BEATS_BURST))
      else $error("cycle ended after a wrong count of ready strobes");
   a_next_addr_busy: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !next_addr_n_o |-> $past(state_r) == HCBI_CYCLE ##1 next_addr_n_o)
      else $error("next address outside a cycle or held too long");
   a_snoop_sequence: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      $fell(addr_hold_req_n_o) |-> s_hold_strobe ##1 s_hold_wait)
      else $error("inquiry steps out of order");
   a_inv_level_snoop: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !snoop_addr_strobe_n_o |-> cache_en_invalidate_o == snp_r.write)
      else $error("invalidate level wrong for snoop direction");
   a_backoff_follow: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      backoff_req_i && in_cyc_w && !boff_w && !last_w |=> !cpu_backoff_n_o ##1 cyc_abort_o)
      else $error("back-off late or cycle not abandoned");
   a_block_release: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      $fell(line_block_o) |-> cyc_done_o && req_o.write && req_o.cacheable)
      else $error("line block released before write-back ended");
   a_lock_defers: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      $fell(addr_hold_req_n_o) |-> !$past(locked_seq_o))
      else $error("snoop started inside a locked sequence");
endmodule
`default_nettype wire

// ### logic/hcbi_map.svh
// Named constants for the host processor bus interface.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef HCBI_MAP_SVH
`define HCBI_MAP_SVH

// ----------------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------------
`define HCBI_ADDR_W 29
`define HCBI_DATA_W 64
`define HCBI_BE_W 8

// ----------------------------------------------------------------------
// Beat counts and reset values
// ----------------------------------------------------------------------
`define HCBI_BEAT_W 3
`define HCBI_BEAT_ZERO 3'h0
`define HCBI_BEAT_ONE 3'h1
`define HCBI_BEATS_SINGLE 3'h1
`define HCBI_BEATS_BURST 3'h4
`define HCBI_BE_ALL 8'hff
`define HCBI_ADDR_ZERO 29'h0000_0000
`define HCBI_DATA_ZERO 64'h0000_0000_0000_0000

// ----------------------------------------------------------------------
// Snoop timing: wait count after the strobe before hit-modified is read
// ----------------------------------------------------------------------
`define HCBI_HITM_CNT_W 2
`define HCBI_HITM_CNT_ZERO 2'h0
`define HCBI_HITM_CNT_ONE 2'h1
`define HCBI_HITM_LAST 2'h1

`endif

// ### logic/hcbi_pkg.sv
// Types shared by the host processor bus interface modules.
// Assumes hcbi_map.svh is on the include path.
`include "hcbi_map.svh"

package hcbi_pkg;

   // -------------------------------------------------------------------
   // Interface states
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      HCBI_IDLE,
      HCBI_CYCLE,
      HCBI_AHOLD,
      HCBI_STROBE,
      HCBI_SNWAIT
   } hcbi_state_t;

   // -------------------------------------------------------------------
   // One decoded processor cycle, all fields active high
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [`HCBI_ADDR_W-1:0] addr; // Quadword address
      logic [`HCBI_BE_W-1:0] be;     // Lane enables, bit 7 is the top byte
      logic write;                   // Write when set, read when clear
      logic mem;                     // Memory when set, I/O when clear
      logic data;                    // Data when set, code fetch when clear
      logic lock;                    // Part of a locked sequence
      logic cacheable;               // Line fill or write-back announced
      logic smm;                     // System management mode active
   } hcbi_cycle_t;

   // -------------------------------------------------------------------
   // One inquiry request from the PCI side
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [`HCBI_ADDR_W-1:0] addr; // Address to snoop
      logic write;                   // PCI master write when set
   } hcbi_snoop_t;

   // Active-low pin to active-high flag
   function automatic logic hcbi_act(input logic pin_n);
      return ~pin_n;
   endfunction

endpackage

// ### logic/hcbi_cycle_decode.sv
// Captures and classifies a processor cycle on its address strobe.
// Assumes the processor pins are synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none
`include "hcbi_map.svh"

module hcbi_cycle_decode (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Processor pins
   input wire logic cycle_addr_strobe_n_i,
   input wire logic [`HCBI_ADDR_W-1:0] host_addr_lines_i,
   input wire logic [`HCBI_BE_W-1:0] host_byte_lane_enables_n_i,
   input wire logic write_or_read_sel_i,
   input wire logic mem_or_io_sel_i,
   input wire logic data_or_code_sel_i,
   input wire logic host_locked_cycle_n_i,
   input wire logic cpu_cacheable_n_i,
   input wire logic sys_mgmt_active_n_i,
   // Decoded cycle
   output logic dec_vld_o,
   output hcbi_pkg::hcbi_cycle_t dec_cyc_o
);
   import hcbi_pkg::*;

   // -------------------------------------------------------------------
   // Classification
   // -------------------------------------------------------------------
   wire logic strobe_w = hcbi_act(cycle_addr_strobe_n_i); // New cycle
   wire logic mem_rd_w = mem_or_io_sel_i & ~write_or_read_sel_i; // Memory read
   // Lane enables only matter outside memory reads and fills
   wire logic [`HCBI_BE_W-1:0] be_w = mem_rd_w ? `HCBI_BE_ALL : ~host_byte_lane_enables_n_i;
   hcbi_cycle_t cyc_w;

   assign cyc_w.addr = host_addr_lines_i;
   assign cyc_w.be = be_w;
   assign cyc_w.write = write_or_read_sel_i;
   assign cyc_w.mem = mem_or_io_sel_i;
   assign cyc_w.data = data_or_code_sel_i;
   assign cyc_w.lock = hcbi_act(host_locked_cycle_n_i);
   assign cyc_w.cacheable = hcbi_act(cpu_cacheable_n_i);
   assign cyc_w.smm = hcbi_act(sys_mgmt_active_n_i);

   // Capture register, pulses valid once per strobe
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         dec_vld_o <= 1'b0;
         dec_cyc_o <= '0;
      end else begin
         dec_vld_o <= strobe_w;
         dec_cyc_o <= strobe_w ? cyc_w : dec_cyc_o;
      end
   end

endmodule
`default_nettype wire

// ### tb/hcbi_cpu_model.sv
// Processor model standing on the far side of the host bus interface.
// Assumes the bench raises go_i for one falling-edge cycle per request.
`timescale 1ns/1ps
`default_nettype none
module hcbi_cpu_model
   import hcbi_pkg::*;
(
   // Clock and bench control
   input wire logic mclk_i,
   input wire logic go_i,
   input wire hcbi_cycle_t cyc_i,
   input wire logic hitm_en_i,
   // Bridge outputs watched
   input wire logic eads_n_i,
   input wire logic brdy_n_i,
   // Processor pins, attributes active high
   output logic ads_n_o = 1'b1,
   output hcbi_cycle_t pin_o = '0,
   output logic hitm_n_o = 1'b1,
   output int brdy_cnt_o = 0
);
   logic [1:0] hitm_cnt = 2'h0; // Cycles of hit-modified still to show
   // Strobe, attributes, snoop answer and ready count, all after the edge
   always @(posedge mclk_i) begin
      ads_n_o <= ~go_i;
      if (go_i) begin
         pin_o <= cyc_i;
      end else if (!ads_n_o) begin
         pin_o.addr <= ~pin_o.addr; // Released lines show the inverse
      end
      if (!eads_n_i && hitm_en_i) begin
         hitm_cnt <= 2'h2;
         hitm_n_o <= 1'b0;
      end else if (hitm_cnt != 2'h0) begin
         hitm_cnt <= hitm_cnt - 2'h1;
         hitm_n_o <= (hitm_cnt == 2'h1);
      end
      if (go_i) begin
         brdy_cnt_o <= 0;
      end else if (!brdy_n_i) begin
         brdy_cnt_o <= brdy_cnt_o + 1; // Cycle ends after the count
      end
   end
endmodule
`default_nettype wire

// ### tb/hcbi_host_if_tb.sv
// Self-checking bench for the host processor bus interface.
// Assumes the design files and the processor model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "hcbi_map.svh"
module hcbi_host_if_tb;
   import hcbi_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam logic [63:0] WD = 64'h0123_4567_89ab_cdef; // Write data
   localparam logic [63:0] RD = 64'hfedc_ba98_7654_3210; // Read data
   logic mclk_i = 1'b0, resetn_i = 1'b0, go = 1'b0, hitm_en = 1'b0, sreq = 1'b0;
   logic beat = 1'b0, ken = 1'b0, pipe = 1'b0, boff_req = 1'b0, na_seen = 1'b0;
   logic ads_n, hitm_n, ha_oe, hd_oe, brdy_n, na_n, aho_n, eads_n, boff_n, inv, eads;
   logic req_vld, wr_vld, done, abort, ack, hit, blk, lk, sm;
   logic [`HCBI_ADDR_W-1:0] ha_o, ha;
   logic [`HCBI_DATA_W-1:0] hd_o, wr_data;
   hcbi_snoop_t snp = '0;
   hcbi_cycle_t cyc = '0, pin, req;
   int bcnt, err_count = 0, n_tests = 0;
   assign ha = ha_oe ? ha_o : pin.addr; // Level of the shared address lines
   assign eads = ~eads_n;
   hcbi_cpu_model cpu (.mclk_i(mclk_i), .go_i(go), .cyc_i(cyc), .hitm_en_i(hitm_en),
      .eads_n_i(eads_n), .brdy_n_i(brdy_n), .ads_n_o(ads_n), .pin_o(pin),
      .hitm_n_o(hitm_n), .brdy_cnt_o(bcnt));
   hcbi_host_if uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .host_addr_lines_i(ha),
      .host_addr_lines_o(ha_o), .host_addr_lines_oe_o(ha_oe),
      .host_byte_lane_enables_n_i(~pin.be), .cycle_addr_strobe_n_i(ads_n),
      .write_or_read_sel_i(pin.write), .mem_or_io_sel_i(pin.mem),
      .data_or_code_sel_i(pin.data), .host_locked_cycle_n_i(~pin.lock),
      .cpu_cacheable_n_i(~pin.cacheable), .sys_mgmt_active_n_i(~pin.smm),
      .snoop_hit_modified_n_i(hitm_n), .host_data_lines_i(WD), .host_data_lines_o(hd_o),
      .host_data_lines_oe_o(hd_oe), .burst_ready_n_o(brdy_n), .next_addr_n_o(na_n),
      .addr_hold_req_n_o(aho_n), .snoop_addr_strobe_n_o(eads_n), .cpu_backoff_n_o(boff_n),
      .cache_en_invalidate_o(inv), .req_vld_o(req_vld), .req_o(req), .beat_rdy_i(beat),
      .ken_i(ken), .pipe_en_i(pipe), .rd_data_i(RD), .wr_data_o(wr_data),
      .wr_vld_o(wr_vld), .cyc_done_o(done), .cyc_abort_o(abort),
      .backoff_req_i(boff_req), .snoop_req_i(sreq), .snoop_i(snp), .snoop_ack_o(ack),
      .snoop_hit_o(hit), .line_block_o(blk), .locked_seq_o(lk), .smm_active_o(sm));
   // ------------------------------------------------------------
   // Clock, watchdog and helpers
   // ------------------------------------------------------------
   initial begin
      forever #2.5 mclk_i = ~mclk_i;
   end
   // Next-address pulse seen since the last strobe request
   always @(posedge mclk_i) begin
      na_seen <= go ? 1'b0 : (na_seen | ~na_n);
   end
   initial begin
      #20us;
      err_count++;
      end_sim();
   end
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e) begin
         $display("[FAIL] %s exp %h got %h", nm, e, g);
         err_count++;
      end
   endtask
   // Bounded wait at falling edges for a design flag
   task automatic wait_hi(ref logic s, input string nm);
      int k;
      k = 0;
      while (s !== 1'b1 && k < 40) begin
         @(negedge mclk_i);
         k++;
      end
      chk(nm, 64'h1, {63'h0, s});
   endtask
   task automatic start_cyc(input hcbi_cycle_t c, input logic k);
      hcbi_cycle_t e;
      e = c;
      if (c.mem && !c.write) e.be = 8'hff;
      cyc = c;
      ken = k;
      go = 1'b1;
      @(negedge mclk_i);
      go = 1'b0;
      wait_hi(req_vld, "req_vld_o");
      chk("req_o", e, req);
      chk("status", {c.lock, c.smm}, {lk, sm});
   endtask
   task automatic run_cyc(input hcbi_cycle_t c, input logic k, input int n);
      start_cyc(c, k);
      beat = 1'b1;
      wait_hi(done, "cyc_done_o");
      beat = 1'b0;
      chk("data", c.write ? WD : RD, c.write ? wr_data : hd_o);
      chk("data strobes", c.write ? 2'h2 : 2'h1, {wr_vld, hd_oe});
      chk("cache_en_invalidate_o", !k, inv);
      @(negedge mclk_i);
      chk("ready count", n, bcnt);
   endtask
   task automatic snp_run(input logic [28:0] a, input logic w, input logic h);
      snp = '{a, w};
      hitm_en = h;
      sreq = 1'b1;
      wait_hi(eads, "snoop strobe");
      chk("snoop drive", {1'b0, 1'b1, w, a}, {aho_n, ha_oe, inv, ha});
      wait_hi(ack, "snoop_ack_o");
      sreq = 1'b0;
      hitm_en = 1'b0;
      chk("snoop_hit_o", h, hit);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      @(negedge mclk_i);
      chk("idle outputs", 8'hfc, {brdy_n, na_n, aho_n, eads_n, boff_n, inv, ha_oe, hd_oe});
      $display("t_reset done");
   endtask
   task automatic t_cycles();
      run_cyc('{29'h0000_0123, 8'h0f, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1}, 1'b1, 1);
      snp = '{29'h0000_0088, 1'b0};
      sreq = 1'b1;
      repeat (3) @(negedge mclk_i);
      chk("snoop deferred", 1, aho_n);
      sreq = 1'b0;
      run_cyc('{29'h0000_0456, 8'h01, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0}, 1'b0, 1);
      pipe = 1'b1;
      run_cyc('{29'h1fff_fffc, 8'h80, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0}, 1'b1, 4);
      pipe = 1'b0;
      chk("next_addr_n_o pulse", 1, na_seen);
      $display("t_cycles done");
   endtask
   task automatic t_snoop_wb();
      snp_run(29'h0000_0040, 1'b1, 1'b1);
      chk("line_block_o set", 1, blk);
      run_cyc('{29'h0000_0040, 8'hff, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0}, 1'b0, 4);
      chk("line_block_o clear", 0, blk);
      snp_run(29'h0aaa_5555, 1'b0, 1'b0);
      $display("t_snoop_wb done");
   endtask
   task automatic t_backoff();
      start_cyc('{29'h0000_0789, 8'hf0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0}, 1'b0);
      boff_req = 1'b1;
      wait_hi(abort, "cyc_abort_o");
      chk("cpu_backoff_n_o low", 0, boff_n);
      boff_req = 1'b0;
      repeat (2) @(negedge mclk_i);
      chk("cpu_backoff_n_o high", 1, boff_n);
      $display("t_backoff done");
   endtask
   initial begin
      repeat (20) @(negedge mclk_i);
      resetn_i = 1'b1;
      t_reset();
      t_cycles();
      t_snoop_wb();
      t_backoff();
      end_sim();
   end
endmodule
`default_nettype wire
